// >>> hdl/sadc_regs.svh
// timing and field constants for the converter control block
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
`define SADC_CLK_MHZ 20
`define SADC_CONV_TIME_NS 610
`define SADC_CONV_CYC ((`SADC_CONV_TIME_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_LEAD_TIME_NS 100
`define SADC_LEAD_CYC ((`SADC_LEAD_TIME_NS * `SADC_CLK_MHZ + 999) / 1000)
`define SADC_RES_W 18
`define SADC_RESULT_RST 18'h00000
`define SADC_ONES_W 6
`endif

// >>> hdl/sadc_pkg.sv
// types shared by the converter control block
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_SAMPLE,
    SADC_HOLD,
    SADC_CONVERT
  } sadc_state_e;
  typedef logic [17:0] sadc_word_t;
  typedef struct packed {
    logic conversion_start_n;
    logic device_select_n;
    logic output_read_n;
    logic middle_bits_select;
    logic low_bits_select;
  } sadc_strobe_s;
endpackage : sadc_pkg

// >>> hdl/sadc_ctrl.sv
// conversion control and result bus for the 18-bit converter
//
// Operation
// RL1: conversion completes within 610 ns
// RL2: timing from internal clock, no external clock
// RL3: host holds start low 20 ns with select
// RL4: start falling edge stops sampling, holds input; a select fall in the same cycle keeps sample_en high
// RL5: busy rises at start, falls when done
// RL6: sampling restarts lead delay before busy falls
// RL7: select must be low when start falls
// RL8: drive bus only when select and read low
// RL9: analog inputs disconnected during conversion
// RL10: host treats busy fall as data ready
// RL11: host avoids reads around start falling edge
// RL12: two's complement result, bus otherwise undriven
// RL13: steer bits by selects, unused pins ones
// RL14: start or select during conversion resets converter
// RL15: host reads after busy falls, then starts
`timescale 1ns/100ps
`default_nettype none
`include "sadc_regs.svh"
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int CONV_CYC = `SADC_CONV_CYC,
  parameter int LEAD_CYC = `SADC_LEAD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire sadc_strobe_s strobe_pin,
  input wire sadc_word_t sar_code,
  output logic busy,
  output logic sample_en,
  output logic analog_connect,
  output logic sample_start,
  output sadc_word_t result_bus_o,
  output logic result_bus_oe
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  sadc_strobe_s strobe_meta_r;
  sadc_strobe_s strobe_r;
  sadc_strobe_s strobe_d_r;
  // two stages so that pin metastability never reaches logic
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      strobe_meta_r <= '1;
      strobe_r <= '1;
      strobe_d_r <= '1;
    end else begin
      strobe_meta_r <= strobe_pin;
      strobe_r <= strobe_meta_r;
      strobe_d_r <= strobe_r;
    end
  end

  // select edges count only once both stages hold real pin values
  logic [1:0] prime_r;
  logic primed;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prime_r <= 2'h0;
    end else if (prime_r != 2'h3) begin
      prime_r <= prime_r + 2'h1;
    end
  end
  // a select already low at reset must not pose as a fresh fall
  assign primed = (prime_r == 2'h3);

  logic start_fall;
  logic select_fall;
  assign start_fall = strobe_d_r.conversion_start_n &
                      !strobe_r.conversion_start_n &
                      !strobe_r.device_select_n; // see RL7
  assign select_fall = primed & strobe_d_r.device_select_n &
                       !strobe_r.device_select_n;

  // ==========================================================
  // conversion sequencer
  // ==========================================================
  sadc_state_e state_r;
  logic [15:0] count_r;
  logic abort;
  logic done;
  // an abort restarts sampling and wipes the latched result
  assign abort = (state_r == SADC_CONVERT) &
                 (start_fall | select_fall); // see RL14
  assign done = (state_r == SADC_CONVERT) &
                (count_r == 16'(CONV_CYC - 1)); // see RL1

  // internal clock paces the whole conversion
  always_ff @(posedge mclk) begin // see RL2
    if (!resetn) begin
      state_r <= SADC_SAMPLE;
      count_r <= 16'h0000;
    end else begin
      case (state_r)
        SADC_SAMPLE: begin
          count_r <= 16'h0000;
          if (start_fall) begin
            state_r <= SADC_CONVERT; // see RL4
          end
        end
        SADC_CONVERT: begin
          if (abort || done) begin
            state_r <= SADC_SAMPLE;
            count_r <= 16'h0000;
          end else begin
            count_r <= count_r + 16'h0001;
          end
        end
        default: begin
          state_r <= SADC_SAMPLE;
          count_r <= 16'h0000;
        end
      endcase
    end
  end

  // busy high while converting, from the second convert cycle on
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_r == SADC_CONVERT) & !abort & !done; // see RL5
    end
  end

  // ==========================================================
  // sampling switch
  // ==========================================================
  logic lead_hit;
  logic select_tied_r;
  // lead point sits LEAD_CYC cycles ahead of the done cycle
  assign lead_hit = (state_r == SADC_CONVERT) & !abort &
                    (count_r == 16'(CONV_CYC - 1 - LEAD_CYC));
  // select held low through the conversion counts as tied low
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      select_tied_r <= 1'b0;
    end else if (start_fall) begin
      select_tied_r <= 1'b1;
    end else if (strobe_r.device_select_n) begin
      select_tied_r <= 1'b0;
    end
  end

  // sampling opens early with select tied, else on select fall
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sample_en <= 1'b1;
      sample_start <= 1'b0;
    end else begin
      sample_start <= 1'b0;
      // the switch stays open once reopened; only a start closes it
      if (start_fall) begin
        sample_en <= 1'b0; // see RL4
      end
      if (lead_hit && select_tied_r) begin
        sample_en <= 1'b1; // see RL6
        sample_start <= 1'b1;
      end else if (abort) begin
        sample_en <= 1'b1; // see RL14
        sample_start <= 1'b1;
      end else if (select_fall && !busy) begin
        sample_en <= 1'b1; // see RL6
        sample_start <= 1'b1;
      end
    end
  end

  // inputs isolated while busy is high, from the second convert cycle on
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      analog_connect <= 1'b1;
    end else begin
      analog_connect <= !((state_r == SADC_CONVERT) & !abort & !done);
    end // see RL9
  end

  // ==========================================================
  // result latch and bus steering
  // ==========================================================
  sadc_word_t result_r;
  // result is two's complement straight from the array
  // sar_code must already be settled on the done cycle
  always_ff @(posedge mclk) begin
    if (!resetn || abort) begin
      result_r <= `SADC_RESULT_RST; // see RL14
    end else if (done) begin
      result_r <= sar_code; // see RL12
    end
  end

  sadc_word_t steer_nxt;
  // unused lanes read ones so narrow hosts see a fixed pattern
  always_comb begin
    steer_nxt = '1;
    case ({strobe_r.middle_bits_select, strobe_r.low_bits_select})
      2'b00: steer_nxt = result_r;
      2'b01: steer_nxt[3:2] = result_r[1:0];
      2'b10: steer_nxt[17:10] = result_r[9:2];
      2'b11: steer_nxt[11:10] = result_r[1:0];
      default: steer_nxt = '1;
    endcase // see RL13
  end

  // enable only when both strobes low; data from flops
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      result_bus_o <= `SADC_RESULT_RST;
      result_bus_oe <= 1'b0;
    end else begin
      result_bus_o <= steer_nxt;
      result_bus_oe <= !strobe_r.device_select_n &
                       !strobe_r.output_read_n; // see RL8
    end
  end

endmodule : sadc_ctrl
`default_nettype wire

// >>> sim/sadc_ctrl_chk.sv
// port assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sadc_ctrl_chk
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire sadc_strobe_s strobe_pin,
  input wire logic busy,
  input wire logic sample_en,
  input wire logic analog_connect,
  input wire logic sample_start,
  input wire sadc_word_t result_bus_o,
  input wire logic result_bus_oe
);
  // =========
  // checks; pins pass a synchroniser, hence windows
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic rd = !strobe_pin.device_select_n && !strobe_pin.output_read_n;
  a_oe_cause: assert property (result_bus_oe |->
    $past(rd, 2) || $past(rd, 3) || $past(rd, 4)) else $error("oe");
  a_oe_off: assert property ((!rd)[*4] |-> !result_bus_oe)
    else $error("float");
  a_busy_len: assert property ($rose(busy) |-> ##11 !busy)
    else $error("len");
  a_inputs_off: assert property (busy |-> !analog_connect)
    else $error("input");
  a_hold_first: assert property ($rose(busy) |-> !$past(sample_en))
    else $error("hold");
  a_busy_start: assert property ($fell(strobe_pin.conversion_start_n) &&
    !strobe_pin.device_select_n && !busy |-> ##[2:6] busy) else $error("go");
  a_lead_pulse: assert property (sample_start |=>
    !sample_start ##[0:3] !busy) else $error("lead");
  a_fill_ones: assert property ((strobe_pin.middle_bits_select &&
    strobe_pin.low_bits_select)[*4] ##0 result_bus_oe |->
    &result_bus_o[17:12] && &result_bus_o[9:0]) else $error("ones");
  a_sample_hold: assert property (sample_start |=> sample_en)
    else $error("sampling switch closed after reopening");
  cover property ($fell(busy));
  cover property (sample_start);
  cover property (result_bus_oe);
endmodule : sadc_ctrl_chk
bind sadc_ctrl sadc_ctrl_chk u_chk (
  .mclk(mclk),
  .resetn(resetn),
  .strobe_pin(strobe_pin),
  .busy(busy),
  .sample_en(sample_en),
  .analog_connect(analog_connect),
  .sample_start(sample_start),
  .result_bus_o(result_bus_o),
  .result_bus_oe(result_bus_oe)
);
`default_nettype wire

// >>> sim/sadc_host.sv
// host model driving the converter strobes
`timescale 1ns/100ps
`default_nettype none
module sadc_host
  import sadc_pkg::*;
(
  input wire logic mclk,
  input wire logic busy,
  input wire sadc_word_t result_bus_o,
  input wire logic result_bus_oe,
  output var sadc_strobe_s strobe_pin
);
  // =========
  // host; select kept low as if tied
  initial strobe_pin = 5'h14;
  // three cycles, start low or select high, well over the minimum width
  task pulse(input logic by_sel);
    @(posedge mclk);
    if (by_sel) strobe_pin.device_select_n <= 1'b1;
    else strobe_pin.conversion_start_n <= 1'b0;
    repeat (3) @(posedge mclk);
    strobe_pin.conversion_start_n <= 1'b1;
    strobe_pin.device_select_n <= 1'b0;
  endtask : pulse
  // busy fall is the ready event; kill 1 or 2 aborts early
  task conv(input int kill, output int hi);
    hi = 0;
    pulse(1'b0);
    while (!busy && hi < 9) begin
      @(negedge mclk);
      hi++;
    end
    hi = 0;
    while (busy && hi < 30) begin
      hi++;
      if (hi == 1 && kill > 0) pulse(kill == 2);
      @(negedge mclk);
    end
  endtask : conv
  // reads only while idle, released a cycle before any start
  task rd(input logic [1:0] s, output sadc_word_t d, output logic oe);
    @(posedge mclk);
    strobe_pin.middle_bits_select <= s[1];
    strobe_pin.low_bits_select <= s[0];
    strobe_pin.output_read_n <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    d = result_bus_o;
    oe = result_bus_oe;
    @(posedge mclk) strobe_pin.output_read_n <= 1'b1;
  endtask : rd
endmodule : sadc_host
`default_nettype wire

// >>> sim/sadc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sadc_ctrl_tb;
  import sadc_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  sadc_word_t sar_code = '0;
  sadc_strobe_s strobe_pin;
  logic busy, sample_en, analog_connect, sample_start, result_bus_oe;
  sadc_word_t result_bus_o, d;
  logic oe;
  int n_fail = 0, checks = 0, seed = 32'h6093b8f9, hi;
  int n_start = 0, n_prev = 0;
  // =========
  // harness
  always #25 mclk = ~mclk;
  sadc_ctrl u_sadc_ctrl (
    .mclk(mclk),
    .resetn(resetn),
    .strobe_pin(strobe_pin),
    .sar_code(sar_code),
    .busy(busy),
    .sample_en(sample_en),
    .analog_connect(analog_connect),
    .sample_start(sample_start),
    .result_bus_o(result_bus_o),
    .result_bus_oe(result_bus_oe)
  );
  sadc_host u_sadc_host (
    .mclk(mclk),
    .busy(busy),
    .result_bus_o(result_bus_o),
    .result_bus_oe(result_bus_oe),
    .strobe_pin(strobe_pin)
  );
  // count reopenings of the sampling switch, away from the launch edge
  always @(negedge mclk) begin
    if (sample_start) n_start++;
  end
  // unused pins read as ones
  function automatic sadc_word_t steer(sadc_word_t c, logic [1:0] s);
    steer = '1;
    case (s)
      2'b00: steer = c;
      2'b01: steer[3:2] = c[1:0];
      2'b10: steer[17:10] = c[9:2];
      default: steer[11:10] = c[1:0];
    endcase
  endfunction : steer
  task cmp(input sadc_word_t got, input sadc_word_t exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask : cmp
  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // main sequence; codes random, with both extremes
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    cmp(18'({busy, sample_en, analog_connect, result_bus_oe}), 18'h6);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      sar_code <= k == 0 ? 18'h1ffff : k == 7 ? 18'h20000 : 18'($random(seed));
      n_prev = n_start;
      u_sadc_host.conv(0, hi);
      cmp(18'(hi), 18'hb);
      cmp(18'({busy, analog_connect, sample_en}), 18'h3);
      cmp(18'(result_bus_oe), 18'h0);
      for (int s = 0; s < 4; s++) begin
        u_sadc_host.rd(2'(s), d, oe);
        cmp(d, steer(sar_code, 2'(s)));
        cmp(18'(oe), 18'h1);
      end
      cmp(18'(n_start - n_prev), 18'h1);
      $display("conversion %0d done", k);
    end
    for (int k = 1; k < 3; k++) begin
      n_prev = n_start;
      u_sadc_host.conv(k, hi);
      cmp(18'({busy, sample_en}), 18'h1);
      u_sadc_host.rd(2'b00, d, oe);
      cmp(d, 18'h0);
      cmp(18'(oe), 18'h1);
      cmp(18'(n_start - n_prev), 18'h1);
      $display("abort %0d done", k);
    end
    end_sim();
  end
  // about ten times the expected run
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule : sadc_ctrl_tb
`default_nettype wire
